// file: svsc_defs.vh
`ifndef SVSC_DEFS_VH
`define SVSC_DEFS_VH

// ----------------------------------------
// register indices, byte address is index times four
// ----------------------------------------
`define SVSC_CTL_IDX 10'h056
`define SVSC_IST_IDX 10'h057
`define SVSC_IMSK_IDX 10'h058

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SVSC_LVL_HI 7
`define SVSC_LVL_LO 4
`define SVSC_RESET_ON_LOW_ENABLE_BIT 3
`define SVSC_ACT_BIT 2
`define SVSC_COMP_BIT 1
`define SVSC_FLAG_BIT 0
`define SVSC_LVL_OFF 4'h0
`define SVSC_LVL_EXT 4'hF
`define SVSC_CTL_RST 8'h00

// ----------------------------------------
// interrupt status and mask fields
// ----------------------------------------
`define SVSC_EV_FLAG 0
`define SVSC_EV_ACTIVE 1
`define SVSC_EV_W 2
`define SVSC_EV_RST 2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define SVSC_CLK_MHZ 25
`define SVSC_TON_US 50
`define SVSC_TSET_US 12
`define SVSC_TON_CYC (`SVSC_TON_US * `SVSC_CLK_MHZ)
`define SVSC_TSET_CYC (`SVSC_TSET_US * `SVSC_CLK_MHZ)
`define SVSC_DLY_W 11

// ----------------------------------------
// bus answers
// ----------------------------------------
`define SVSC_RESP_OKAY 2'h0
`define SVSC_RESP_SLVERR 2'h2

`endif

// file: svsc_sync.v
// two-flop synchroniser; only the second stage leaves this module
module svsc_sync
(
   input wire clk,
   input wire rstn,
   input wire din,
   output reg dout_r
);

reg meta_r;

always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      meta_r <= 1'b0;
      dout_r <= 1'b0;
   end
   else
   begin
      meta_r <= din;
      dout_r <= meta_r;
   end
end

endmodule // svsc_sync

// file: svsc_delay.v
// down counter for the turn-on and settling delays
module svsc_delay
#(
   parameter W = 11
)
(
   input wire clk,
   input wire rstn,
   input wire load,
   input wire abort,
   input wire [W-1:0] cycles,
   output reg busy_r,
   output reg done_r
);

reg [W-1:0] cnt_r;

always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      cnt_r <= {W{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
   end
   else
   begin
      done_r <= 1'b0;
      if (abort)
      begin
         cnt_r <= {W{1'b0}};
         busy_r <= 1'b0;
      end
      else if (load)
      begin
         cnt_r <= cycles;
         busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
         if (cnt_r == {{(W-1){1'b0}}, 1'b1})
         begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
         end
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
   end
end

endmodule // svsc_delay

// file: svsc_top.v
// Register access over AXI4-Lite was chosen for this implementation.
`include "svsc_defs.vh"
module svsc_top
#(
   parameter ADDR_W = 12,
   parameter TON_CYC = `SVSC_TON_CYC,
   parameter TSET_CYC = `SVSC_TSET_CYC
)
(
   input wire clk,
   input wire rstn,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire comparator_low,
   output reg [3:0] level_select_r,
   output reg supply_supervisor_on_r,
   output reg external_sense_select_r,
   output reg por_request_r,
   output reg irq_r
);

// ----------------------------------------
// helpers
// ----------------------------------------
function hit;
   input [ADDR_W-1:0] addr;
   input [9:0] idx;
   begin
      hit = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (addr[1:0] == 2'h0);
   end
endfunction

function mapped;
   input [ADDR_W-1:0] addr;
   begin
      mapped = hit(addr, `SVSC_CTL_IDX) || hit(addr, `SVSC_IST_IDX) || hit(addr, `SVSC_IMSK_IDX);
   end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
localparam [7:0] CTL_RST = `SVSC_CTL_RST;

reg reset_on_low_enable_r;
reg low_voltage_flag_r;
reg [`SVSC_EV_W-1:0] irq_status_r;
reg [`SVSC_EV_W-1:0] irq_mask_r;
reg aw_have_r;
reg w_have_r;
reg [ADDR_W-1:0] awaddr_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;

wire comp_low_s;
wire ton_busy;
wire ton_done;
wire tset_busy;
wire tset_done;

// ----------------------------------------
// comparator input
// ----------------------------------------
svsc_sync u_sync
(
   .clk(clk),
   .rstn(rstn),
   .din(comparator_low),
   .dout_r(comp_low_s)
);

// ----------------------------------------
// write channel
// ----------------------------------------
wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
wire wr_ctl = wr_go && hit(awaddr_r, `SVSC_CTL_IDX) && wstrb_r[0];
wire wr_ist = wr_go && hit(awaddr_r, `SVSC_IST_IDX) && wstrb_r[0];
wire wr_imsk = wr_go && hit(awaddr_r, `SVSC_IMSK_IDX) && wstrb_r[0];
wire [3:0] new_level = wdata_r[`SVSC_LVL_HI:`SVSC_LVL_LO];

always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= {ADDR_W{1'b0}};
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SVSC_RESP_OKAY;
   end
   else
   begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(awaddr_r) ? `SVSC_RESP_OKAY : `SVSC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end
   end
end

// ----------------------------------------
// delays
// ----------------------------------------
// a new level only restarts settling if it really differs
wire lvl_on = wr_ctl && (level_select_r == `SVSC_LVL_OFF) && (new_level != `SVSC_LVL_OFF);
wire lvl_move = wr_ctl && (level_select_r != `SVSC_LVL_OFF) && (new_level != `SVSC_LVL_OFF)
   && (new_level != level_select_r);
wire lvl_off = wr_ctl && (new_level == `SVSC_LVL_OFF);

svsc_delay #(.W(`SVSC_DLY_W)) u_ton
(
   .clk(clk),
   .rstn(rstn),
   .load(lvl_on),
   .abort(lvl_off || lvl_move),
   .cycles(TON_CYC[`SVSC_DLY_W-1:0]),
   .busy_r(ton_busy),
   .done_r(ton_done)
);

svsc_delay #(.W(`SVSC_DLY_W)) u_tset
(
   .clk(clk),
   .rstn(rstn),
   .load(lvl_move),
   .abort(lvl_off || lvl_on),
   .cycles(TSET_CYC[`SVSC_DLY_W-1:0]),
   .busy_r(tset_busy),
   .done_r(tset_done)
);

// monitoring counts only once settled; the write cycle itself is also masked
wire settling = ton_busy || tset_busy || lvl_on || lvl_move;
wire monitoring = (level_select_r != `SVSC_LVL_OFF) && !settling;
wire low_event = monitoring && comp_low_s;

// ----------------------------------------
// control register, brownout reset only
// ----------------------------------------
reg flag_nxt;

always @*
begin
   flag_nxt = low_voltage_flag_r;
   if (wr_ctl)
   begin
      flag_nxt = wdata_r[`SVSC_FLAG_BIT];
   end
   if (low_event)
   begin
      flag_nxt = 1'b1;
   end
end

// rstn is the brownout reset; no other reset reaches this register
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      level_select_r <= CTL_RST[`SVSC_LVL_HI:`SVSC_LVL_LO];
      reset_on_low_enable_r <= CTL_RST[`SVSC_RESET_ON_LOW_ENABLE_BIT];
      low_voltage_flag_r <= CTL_RST[`SVSC_FLAG_BIT];
      supply_supervisor_on_r <= 1'b0;
      external_sense_select_r <= 1'b0;
   end
   else
   begin
      low_voltage_flag_r <= flag_nxt;
      if (wr_ctl)
      begin
         level_select_r <= new_level;
         reset_on_low_enable_r <= wdata_r[`SVSC_RESET_ON_LOW_ENABLE_BIT];
         supply_supervisor_on_r <= (new_level != `SVSC_LVL_OFF);
         external_sense_select_r <= (new_level == `SVSC_LVL_EXT);
      end
   end
end

// ----------------------------------------
// reset request
// ----------------------------------------
// one-cycle pulse, while reset on low is enabled, each time a low event sets the flag from clear; a software set of the flag gives no pulse
// a software clear met by a persisting low counts as a fresh set, so the request repeats
wire en_nxt = wr_ctl ? wdata_r[`SVSC_RESET_ON_LOW_ENABLE_BIT] : reset_on_low_enable_r;
wire hw_set = low_event && (!low_voltage_flag_r || (wr_ctl && !wdata_r[`SVSC_FLAG_BIT]));
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      por_request_r <= 1'b0;
   end
   else
   begin
      por_request_r <= en_nxt && hw_set;
   end
end

// ----------------------------------------
// interrupts
// ----------------------------------------
reg [`SVSC_EV_W-1:0] ev;
reg [`SVSC_EV_W-1:0] ist_nxt;

always @*
begin
   ev = {`SVSC_EV_W{1'b0}};
   ev[`SVSC_EV_FLAG] = hw_set;
   ev[`SVSC_EV_ACTIVE] = ton_done || tset_done;
   ist_nxt = irq_status_r;
   if (wr_ist)
   begin
      ist_nxt = ist_nxt & ~wdata_r[`SVSC_EV_W-1:0];
   end
   ist_nxt = ist_nxt | ev; // set wins over clear
end

always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      irq_status_r <= `SVSC_EV_RST;
      irq_mask_r <= `SVSC_EV_RST;
      irq_r <= 1'b0;
   end
   else
   begin
      irq_status_r <= ist_nxt;
      if (wr_imsk)
      begin
         irq_mask_r <= wdata_r[`SVSC_EV_W-1:0];
      end
      irq_r <= |(ist_nxt & (wr_imsk ? wdata_r[`SVSC_EV_W-1:0] : irq_mask_r));
   end
end

// ----------------------------------------
// read channel
// ----------------------------------------
reg [31:0] rd_val;

always @*
begin
   rd_val = 32'h00000000;
   if (hit(s_axi_araddr, `SVSC_CTL_IDX))
   begin
      rd_val[`SVSC_LVL_HI:`SVSC_LVL_LO] = level_select_r;
      rd_val[`SVSC_RESET_ON_LOW_ENABLE_BIT] = reset_on_low_enable_r;
      rd_val[`SVSC_ACT_BIT] = monitoring;
      rd_val[`SVSC_COMP_BIT] = comp_low_s;
      rd_val[`SVSC_FLAG_BIT] = low_voltage_flag_r;
   end
   else if (hit(s_axi_araddr, `SVSC_IST_IDX))
   begin
      rd_val[`SVSC_EV_W-1:0] = irq_status_r;
   end
   else if (hit(s_axi_araddr, `SVSC_IMSK_IDX))
   begin
      rd_val[`SVSC_EV_W-1:0] = irq_mask_r;
   end
end

always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SVSC_RESP_OKAY;
   end
   else
   begin
      if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= mapped(s_axi_araddr) ? `SVSC_RESP_OKAY : `SVSC_RESP_SLVERR;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
      else
      begin
         s_axi_arready <= 1'b1;
      end
   end
end

endmodule // svsc_top

// file: svsc_chk.sv
module svsc_chk
#(
   parameter TON_CYC = 1250,
   parameter TSET_CYC = 300
)
(
   input wire clk,
   input wire rstn,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire comparator_low,
   input wire [3:0] level_select_r,
   input wire supply_supervisor_on_r,
   input wire external_sense_select_r,
   input wire por_request_r
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // delay window; two cycles of slack for the commit edge
   // ----
   reg [10:0] quiet_r;
   always @(posedge clk or negedge rstn)
      if (!rstn)
         quiet_r <= 11'h000;
      else if ($rose(supply_supervisor_on_r))
         quiet_r <= 11'(TON_CYC - 2);
      else if ($changed(level_select_r) && supply_supervisor_on_r)
         quiet_r <= 11'(TSET_CYC - 2);
      else if (quiet_r != 11'h000)
         quiet_r <= quiet_r - 11'h001;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_on; supply_supervisor_on_r == (level_select_r != 4'h0); endproperty
   a_on: assert property (p_on) else $error("on state wrong");
   property p_ext; external_sense_select_r == (level_select_r == 4'hF); endproperty
   a_ext: assert property (p_ext) else $error("sense select wrong");
   property p_quiet; quiet_r != 11'h000 |-> !por_request_r; endproperty
   a_quiet: assert property (p_quiet) else $error("request in delay");
   property p_pulse; por_request_r |=> !por_request_r; endproperty
   a_pulse: assert property (p_pulse) else $error("request too long");
   property p_pormon; por_request_r |-> $past(supply_supervisor_on_r); endproperty
   a_pormon: assert property (p_pormon) else $error("request while off");
   property p_sync; $rose(comparator_low) |-> !por_request_r [*3]; endproperty
   a_sync: assert property (p_sync) else $error("request too early");
   property p_lvlwr; $changed(level_select_r) |-> $rose(s_axi_bvalid); endproperty
   a_lvlwr: assert property (p_lvlwr) else $error("level moved alone");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bhold: assert property (p_bhold) else $error("response dropped");
endmodule // svsc_chk

bind svsc_top svsc_chk #(.TON_CYC(TON_CYC), .TSET_CYC(TSET_CYC)) i_svsc_chk (.clk, .rstn, .s_axi_bvalid,
   .s_axi_bready, .comparator_low, .level_select_r, .supply_supervisor_on_r, .external_sense_select_r,
   .por_request_r);

// file: svsc_cmp_model.sv
module svsc_cmp_model
(
   input wire logic [3:0] level_select_r,
   input wire logic supply_supervisor_on_r,
   input wire logic external_sense_select_r,
   input wire logic [15:0] supply_mv,
   input wire logic [15:0] sense_mv,
   output logic comparator_low
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // thresholds in mV, 1.9 V up to 3.7 V
   // ----
   logic [15:0] thr_mv [0:15] = '{16'h0000, 16'h076C, 16'h0834, 16'h0898, 16'h08FC, 16'h0960, 16'h09C4,
      16'h0A5A, 16'h0AF0, 16'h0B54, 16'h0BEA, 16'h0C80, 16'h0D16, 16'h0DAC, 16'h0E74, 16'h0000};
   // no hysteresis: the comparator flips the moment a level is crossed
   assign comparator_low = supply_supervisor_on_r && (external_sense_select_r ?
      sense_mv < 16'h04B0 : supply_mv < thr_mv[level_select_r]);
endmodule // svsc_cmp_model

// file: svsc_bench.sv
module svsc_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rstn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, comparator_low, irq_r;
   wire supply_supervisor_on_r, external_sense_select_r, por_request_r;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [3:0] level_select_r;
   logic [15:0] supply_mv = 16'h0A28, sense_mv = 16'h044C;
   logic [7:0] d;
   logic [1:0] r;
   int mismatches = 0, checked = 0, cyc = 0, pulses = 0, pn;
   // level in the high nibble, expected readback beside it; supply 2.6 V, sense 1.1 V
   logic [7:0] rows [15] = '{8'h14, 8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h77, 8'h87, 8'h97, 8'hA7, 8'hB7,
      8'hC7, 8'hD7, 8'hE7, 8'hF7};
   svsc_top #(.TON_CYC(20), .TSET_CYC(5)) i_svsc_top (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .comparator_low, .level_select_r, .supply_supervisor_on_r, .external_sense_select_r, .por_request_r, .irq_r);
   svsc_cmp_model i_svsc_cmp_model (.level_select_r, .supply_supervisor_on_r, .external_sense_select_r,
      .supply_mv, .sense_mv, .comparator_low);
   always #20 clk = ~clk;
   always @(posedge clk)
      pulses <= pulses + por_request_r;
   // ----
   // bus tasks and checks
   // ----
   task summarize;
      if (mismatches == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         mismatches++;
         summarize;
      end
   end
   task chk(input [7:0] g, input [7:0] e);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %0t got %h exp %h", $time, g, e);
      end
   endtask
   // both channels offered together, each released on its own ready
   task wr(input [11:0] a, input [7:0] v);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid | s_axi_wvalid);
      while (!s_axi_bvalid)
         @(posedge clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input [11:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd(12'h158);
      chk(d, 8'h00);
      rd(12'h200);
      chk(r, 8'h02);
      wr(12'h158, 8'h04);
      rd(12'h158);
      chk(d, 8'h00);
      foreach (rows[i])
      begin
         wr(12'h158, rows[i] & 8'hF0);
         repeat (30) @(posedge clk);
         rd(12'h158);
         chk(d, rows[i]);
      end
      pn = pulses;
      wr(12'h158, 8'h78);
      repeat (12) @(posedge clk);
      chk(pulses - pn, 8'h01);
      wr(12'h158, 8'h78);
      repeat (4) @(posedge clk);
      chk(pulses - pn, 8'h02);
      wr(12'h158, 8'h70);
      repeat (4) @(posedge clk);
      chk(pulses - pn, 8'h02);
      rd(12'h158);
      chk(d, 8'h77);
      supply_mv <= 16'h0CE4;
      repeat (4) @(posedge clk);
      rd(12'h158);
      chk(d, 8'h75);
      wr(12'h158, 8'h00);
      wr(12'h158, 8'h70);
      rd(12'h158);
      chk(d, 8'h70);
      repeat (30) @(posedge clk);
      wr(12'h15C, 8'h03);
      wr(12'h160, 8'h01);
      chk(irq_r, 8'h00);
      supply_mv <= 16'h0A28;
      repeat (6) @(posedge clk);
      chk(irq_r, 8'h01);
      rd(12'h15C);
      chk(d, 8'h01);
      wr(12'h160, 8'h00);
      repeat (2) @(posedge clk);
      chk(irq_r, 8'h00);
      wr(12'h160, 8'h01);
      wr(12'h15C, 8'h01);
      repeat (2) @(posedge clk);
      chk(irq_r, 8'h00);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(12'h158);
      chk(d, 8'h00);
      wr(12'h200, 8'h00);
      chk(r, 8'h02);
      summarize;
   end
endmodule // svsc_bench
